// [bfc_pkg.sv]
// constants, types and helpers shared by the buck4 configuration bank
package bfc_pkg;

  // register addresses
  localparam logic [15:0] ADDR_CTRL_TWO = 16'h4065;
  localparam logic [15:0] ADDR_ON_CFG = 16'h4066;
  localparam logic [15:0] ADDR_SLEEP_CTRL = 16'h4067;
  localparam logic [15:0] ADDR_STATUS = 16'h40F0;

  // field positions
  localparam int SLOT_LSB = 13;
  localparam int SRC_LSB = 11;
  localparam int PICK_BIT = 10;
  localparam int MODE_LSB = 8;
  localparam int CODE_HI_LSB = 2;

  // reset values
  localparam logic [1:0] HWC_SRC_RST = 2'h0;
  localparam logic HWC_PICK_RST = 1'b0;
  localparam logic [1:0] HWC_MODE_RST = 2'h3;
  localparam logic [2:0] ON_SLOT_RST = 3'h0;
  localparam logic [1:0] ON_MODE_RST = 2'h1;
  localparam logic [6:0] ON_CODE_RST = 7'h00;
  localparam logic [2:0] SLP_SLOT_RST = 3'h0;
  localparam logic [1:0] SLP_MODE_RST = 2'h3;
  localparam logic [6:0] SLP_CODE_RST = 7'h00;

  // hardware-control source codes
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_IN1 = 2'h1;
  localparam logic [1:0] SRC_IN2 = 2'h2;
  localparam logic [1:0] SRC_EITHER = 2'h3;

  // operating modes; under hardware control code 01 means disabled
  localparam logic [1:0] MODE_FCCM = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_HWC_OFF = 2'h1;
  localparam logic [1:0] MODE_LDO = 2'h2;
  localparam logic [1:0] MODE_HYST = 2'h3;

  // slot codes
  localparam logic [2:0] SLOT_NEVER = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] SLOT_HWEN2 = 3'h7;

  // voltage coding
  localparam logic [6:0] CODE_MAX = 7'h66;
  localparam logic [11:0] MV_BASE = 12'h0352;
  localparam logic [11:0] MV_STEP = 12'h0019;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLEEP} bfc_state_type;

  function automatic logic [6:0] bfc_clamp_code(input logic [6:0] c);
    return (c > CODE_MAX) ? CODE_MAX : c;
  endfunction : bfc_clamp_code

endpackage : bfc_pkg

// [bfc_cfg_if.sv]
// configuration fields and status between register bank and core
`timescale 1ns/10ps
interface bfc_cfg_if;
  logic [1:0] hwc_src;
  logic hwc_pick;
  logic [1:0] hwc_mode;
  logic [2:0] on_slot;
  logic [1:0] on_mode;
  logic [6:0] on_code;
  logic [2:0] slp_slot;
  logic [1:0] slp_mode;
  logic [6:0] slp_code;
  logic [15:0] status;

  modport regs (
    output hwc_src, hwc_pick, hwc_mode, on_slot, on_mode, on_code,
    output slp_slot, slp_mode, slp_code,
    input status
  );
  modport core (
    input hwc_src, hwc_pick, hwc_mode, on_slot, on_mode, on_code,
    input slp_slot, slp_mode, slp_code,
    output status
  );
endinterface : bfc_cfg_if

// [bfc_reg_bank.sv]
// register storage, boot load and registered read port
`timescale 1ns/10ps
module bfc_reg_bank (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic boot_load,
  input wire logic [4:0] boot_code_hi,
  bfc_cfg_if.regs cfg
);
  logic [15:0] ctrl_r;
  logic [15:0] on_r;
  logic [15:0] slp_r;
  logic [15:0] rdata_r;
  logic [15:0] rd_sel;
  logic wr_ctrl;
  logic wr_on;
  logic wr_slp;

  assign wr_ctrl = reg_wr && (reg_addr == bfc_pkg::ADDR_CTRL_TWO);
  assign wr_on = reg_wr && (reg_addr == bfc_pkg::ADDR_ON_CFG);
  assign wr_slp = reg_wr && (reg_addr == bfc_pkg::ADDR_SLEEP_CTRL);

  // unused bits never stored, so they read as zero
  assign rd_sel = (reg_addr == bfc_pkg::ADDR_CTRL_TWO) ? ctrl_r :
                  (reg_addr == bfc_pkg::ADDR_ON_CFG) ? on_r :
                  (reg_addr == bfc_pkg::ADDR_SLEEP_CTRL) ? slp_r :
                  (reg_addr == bfc_pkg::ADDR_STATUS) ? cfg.status :
                  16'h0000;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= {3'h0, bfc_pkg::HWC_SRC_RST, bfc_pkg::HWC_PICK_RST,
                 bfc_pkg::HWC_MODE_RST, 8'h00};
      on_r <= {bfc_pkg::ON_SLOT_RST, 3'h0, bfc_pkg::ON_MODE_RST, 1'b0,
               bfc_pkg::ON_CODE_RST};
      slp_r <= {bfc_pkg::SLP_SLOT_RST, 3'h0, bfc_pkg::SLP_MODE_RST, 1'b0,
                bfc_pkg::SLP_CODE_RST};
      rdata_r <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata & 16'h1F00;
      if (wr_on)
        on_r <= reg_wdata & 16'hE37F;
      else if (boot_load)
        on_r[6:2] <= boot_code_hi;
      if (wr_slp)
        slp_r <= reg_wdata & 16'hE37F;
      rdata_r <= reg_rd ? rd_sel : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign cfg.hwc_src = ctrl_r[bfc_pkg::SRC_LSB +: 2];
  assign cfg.hwc_pick = ctrl_r[bfc_pkg::PICK_BIT];
  assign cfg.hwc_mode = ctrl_r[bfc_pkg::MODE_LSB +: 2];
  assign cfg.on_slot = on_r[bfc_pkg::SLOT_LSB +: 3];
  assign cfg.on_mode = on_r[bfc_pkg::MODE_LSB +: 2];
  assign cfg.on_code = on_r[6:0];
  assign cfg.slp_slot = slp_r[bfc_pkg::SLOT_LSB +: 3];
  assign cfg.slp_mode = slp_r[bfc_pkg::MODE_LSB +: 2];
  assign cfg.slp_code = slp_r[6:0];

  a_boot_upper: assert property (@(posedge clock) disable iff (!rstn)
    boot_load && !wr_on |=> on_r[6:2] == $past(boot_code_hi)
      && on_r[1:0] == $past(on_r[1:0]))
    else $error("boot load did not set upper voltage bits");

  a_read_data: assert property (@(posedge clock) disable iff (!rstn)
    reg_rd |=> reg_rdata == $past(rd_sel))
    else $error("read data wrong one cycle after strobe");
endmodule : bfc_reg_bank

// [bfc_volt_conv.sv]
// converts the effective voltage code to millivolts
`timescale 1ns/10ps
module bfc_volt_conv (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [6:0] code,
  output logic [11:0] millivolts
);
  logic [11:0] mv_r;
  logic [11:0] mv_nxt;

  // clamped code keeps the top of the range at the last legal step
  assign mv_nxt = bfc_pkg::MV_BASE
    + {5'h00, bfc_pkg::bfc_clamp_code(code)} * bfc_pkg::MV_STEP;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mv_r <= bfc_pkg::MV_BASE;
    else
      mv_r <= mv_nxt;
  end

  assign millivolts = mv_r;

  a_mv_range: assert property (@(posedge clock) disable iff (!rstn)
    millivolts <= 12'h0D48)
    else $error("output voltage above top of range");
endmodule : bfc_volt_conv

// [bfc_buck4_cfg.sv]
// buck4 configuration bank: registers, power state and effective setting
// Overview of operation
// - under hardware control, voltage picks ON code at 0, SLEEP code at 1
// - hardware mode: 00 forced CCM, 01 off, 10 LDO, 11 hysteretic; reset 11
// - ON slot: 0 never, 1-5 startup slot, 6/7 follow enable input; reset 0
// - ON mode: forced CCM, auto, LDO, hysteretic; resets to auto
// - ON code split 6:2 and 1:0; 0.85V plus 25mV, clamped from 66h
// - only upper five ON code bits load from boot memory
// - SLEEP slot: 0 sleep in 5; 1-5 off in 5..1; 6 sleep 3; 7 sleep 1
// - with hardware enable, codes 1-5 pick sleep slot instead of disable
// - SLEEP mode: forced CCM, pulse skipping, LDO, hysteretic; reset 11
// - SLEEP code bits 6:0 coded like ON code; resets to zero
// - hardware source: none, input 1, input 2, either input
`timescale 1ns/10ps
module bfc_buck4_cfg (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic boot_load,
  input wire logic [4:0] boot_code_hi,
  input wire logic hwctl_pin1,
  input wire logic hwctl_pin2,
  input wire logic hwen_pin1,
  input wire logic hwen_pin2,
  input wire logic seq_valid,
  input wire logic seq_rising,
  input wire logic [2:0] seq_slot,
  output logic conv_enable,
  output logic [1:0] conv_mode,
  output logic [6:0] conv_volt_code,
  output logic [11:0] conv_millivolts
);
  bfc_cfg_if cfg ();

  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic hwc1;
  logic hwc2;
  logic hwen1;
  logic hwen2;
  bfc_pkg::bfc_state_type state_r;
  bfc_pkg::bfc_state_type state_nxt;
  logic enable_r;
  logic [1:0] mode_r;
  logic [6:0] code_r;
  logic enable_nxt;
  logic [1:0] mode_nxt;
  logic [6:0] code_nxt;
  logic hwc_active;
  logic hwc_off;
  logic hw_assigned;
  logic hw_level;
  logic slot_timed;
  logic start_hit;
  logic [2:0] sleep_target;
  logic sleep_disables;
  logic sleep_hit;
  logic wake_hit;
  logic [6:0] on_code_c;
  logic [6:0] slp_code_c;

  function automatic logic [2:0] sleep_slot_of(input logic [2:0] code);
    logic [2:0] s;
    s = 3'h5;
    case (code)
      3'h0: s = 3'h5;
      3'h1: s = 3'h5;
      3'h2: s = 3'h4;
      3'h3: s = 3'h3;
      3'h4: s = 3'h2;
      3'h5: s = 3'h1;
      3'h6: s = 3'h3;
      default: s = 3'h1;
    endcase
    return s;
  endfunction : sleep_slot_of

  bfc_reg_bank u_regs (
    .clock(clock),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .boot_load(boot_load),
    .boot_code_hi(boot_code_hi),
    .cfg(cfg.regs)
  );

  bfc_volt_conv u_conv (
    .clock(clock),
    .rstn(rstn),
    .code(code_r),
    .millivolts(conv_millivolts)
  );

  // pins are asynchronous to the clock
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= {hwen_pin2, hwen_pin1, hwctl_pin2, hwctl_pin1};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign hwc1 = pin_sync_r[0];
  assign hwc2 = pin_sync_r[1];
  assign hwen1 = pin_sync_r[2];
  assign hwen2 = pin_sync_r[3];

  assign hwc_active =
    (cfg.hwc_src == bfc_pkg::SRC_IN1 && hwc1) ||
    (cfg.hwc_src == bfc_pkg::SRC_IN2 && hwc2) ||
    (cfg.hwc_src == bfc_pkg::SRC_EITHER && (hwc1 || hwc2));
  // hardware mode 01 keeps the state but gates the converter off
  assign hwc_off = hwc_active &&
                   (cfg.hwc_mode == bfc_pkg::MODE_HWC_OFF);

  assign hw_assigned = (cfg.on_slot == bfc_pkg::SLOT_HWEN1) ||
                       (cfg.on_slot == bfc_pkg::SLOT_HWEN2);
  assign hw_level = (cfg.on_slot == bfc_pkg::SLOT_HWEN1) ? hwen1 : hwen2;
  assign slot_timed = (cfg.on_slot != bfc_pkg::SLOT_NEVER) &&
                      (cfg.on_slot <= bfc_pkg::SLOT_LAST);
  assign start_hit = seq_valid && seq_rising && slot_timed &&
                     (seq_slot == cfg.on_slot);

  assign sleep_target = sleep_slot_of(cfg.slp_slot);
  assign sleep_disables = (cfg.slp_slot != 3'h0) &&
                          (cfg.slp_slot <= bfc_pkg::SLOT_LAST);
  assign sleep_hit = seq_valid && !seq_rising &&
                     (seq_slot == sleep_target);
  assign wake_hit = seq_valid && seq_rising &&
                    (seq_slot == sleep_target);

  assign on_code_c = bfc_pkg::bfc_clamp_code(cfg.on_code);
  assign slp_code_c = bfc_pkg::bfc_clamp_code(cfg.slp_code);

  // power state; hardware enable overrides the timed sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      bfc_pkg::ST_OFF:
      begin
        if (hw_assigned)
          state_nxt = hw_level ? bfc_pkg::ST_ON : bfc_pkg::ST_OFF;
        else if (start_hit)
          state_nxt = bfc_pkg::ST_ON;
      end
      bfc_pkg::ST_ON:
      begin
        if (hw_assigned && !hw_level)
          state_nxt = bfc_pkg::ST_OFF;
        else if (sleep_hit && sleep_disables && !hw_assigned)
          state_nxt = bfc_pkg::ST_OFF;
        else if (sleep_hit)
          state_nxt = bfc_pkg::ST_SLEEP;
      end
      bfc_pkg::ST_SLEEP:
      begin
        if (hw_assigned && !hw_level)
          state_nxt = bfc_pkg::ST_OFF;
        else if (wake_hit)
          state_nxt = bfc_pkg::ST_ON;
      end
    endcase
  end

  // effective setting presented to the converter
  always_comb
  begin
    enable_nxt = (state_r != bfc_pkg::ST_OFF);
    mode_nxt = cfg.on_mode;
    code_nxt = on_code_c;
    if (state_r == bfc_pkg::ST_SLEEP)
    begin
      mode_nxt = cfg.slp_mode;
      code_nxt = slp_code_c;
    end
    if (hwc_active && state_r != bfc_pkg::ST_OFF)
    begin
      mode_nxt = cfg.hwc_mode;
      code_nxt = cfg.hwc_pick ? slp_code_c : on_code_c;
      if (cfg.hwc_mode == bfc_pkg::MODE_HWC_OFF)
        enable_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= bfc_pkg::ST_OFF;
      enable_r <= 1'b0;
      mode_r <= bfc_pkg::ON_MODE_RST;
      code_r <= bfc_pkg::ON_CODE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      enable_r <= enable_nxt;
      mode_r <= mode_nxt;
      code_r <= code_nxt;
    end
  end

  // status word: state, enable, hw active, mode; code is not reported
  assign cfg.status = {9'h000, state_r, enable_r, hwc_active, mode_r,
                       1'b0};

  assign conv_enable = enable_r;
  assign conv_mode = mode_r;
  assign conv_volt_code = code_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_on_no_hwc;
    state_r == bfc_pkg::ST_ON && !hwc_active;
  endsequence

  sequence s_sleep_entry;
    state_r == bfc_pkg::ST_ON && !(hw_assigned && !hw_level) && sleep_hit;
  endsequence

  sequence s_wake;
    state_r == bfc_pkg::ST_SLEEP && !(hw_assigned && !hw_level) && wake_hit;
  endsequence

  sequence s_hw_drop;
    hw_assigned && !hw_level;
  endsequence

  a_hwc_on_pick: assert property (
    hwc_active && state_r != bfc_pkg::ST_OFF && !cfg.hwc_pick
    |=> conv_volt_code == $past(on_code_c))
    else $error("hardware control did not use the ON code");

  a_hwc_slp_pick: assert property (
    hwc_active && state_r != bfc_pkg::ST_OFF && cfg.hwc_pick
    |=> conv_volt_code == $past(slp_code_c))
    else $error("hardware control did not use the SLEEP code");

  a_hwc_mode_off: assert property (
    hwc_active && state_r != bfc_pkg::ST_OFF
    && cfg.hwc_mode == bfc_pkg::MODE_HWC_OFF |=> !conv_enable)
    else $error("hardware disabled mode left converter on");

  a_slot_start: assert property (
    state_r == bfc_pkg::ST_OFF && !hw_assigned && start_hit
    |=> state_r == bfc_pkg::ST_ON ##1 conv_enable || $past(hwc_off))
    else $error("converter missed its startup slot");

  a_never_enable: assert property (
    state_r == bfc_pkg::ST_OFF && cfg.on_slot == bfc_pkg::SLOT_NEVER
    |=> state_r == bfc_pkg::ST_OFF)
    else $error("converter started with slot never");

  a_on_mode_out: assert property (
    s_on_no_hwc |=> conv_mode == $past(cfg.on_mode))
    else $error("ON mode not presented");

  a_code_clamp: assert property (
    conv_volt_code <= bfc_pkg::CODE_MAX)
    else $error("voltage code above clamp");

  a_sleep_disable: assert property (
    s_sleep_entry ##0 sleep_disables && !hw_assigned
    |=> state_r == bfc_pkg::ST_OFF ##1 !conv_enable)
    else $error("sleep slot did not disable converter");

  a_hw_sleep_slot: assert property (
    s_sleep_entry ##0 hw_assigned |=> state_r == bfc_pkg::ST_SLEEP)
    else $error("assigned converter did not enter sleep");

  a_sleep_mode_out: assert property (
    state_r == bfc_pkg::ST_SLEEP && !hwc_active
    |=> conv_mode == $past(cfg.slp_mode)
      && conv_volt_code == $past(slp_code_c))
    else $error("SLEEP setting not presented");

  a_hwc_source: assert property (
    cfg.hwc_src == bfc_pkg::SRC_NONE |-> !hwc_active)
    else $error("hardware control active with no source");

  a_off_disabled: assert property (
    state_r == bfc_pkg::ST_OFF |=> !conv_enable)
    else $error("converter enabled while off");

  // state moves first, registered outputs settle one edge later
  a_hwc_mode_out: assert property (
    hwc_active && state_r != bfc_pkg::ST_OFF
    |=> conv_mode == $past(cfg.hwc_mode))
    else $error("hardware control mode not presented");

  a_hw_follow_on: assert property (
    state_r == bfc_pkg::ST_OFF && hw_assigned && hw_level
    |=> state_r == bfc_pkg::ST_ON)
    else $error("hardware enable did not start converter");

  a_hw_drop_off: assert property (
    s_hw_drop |=> state_r == bfc_pkg::ST_OFF ##1 !conv_enable)
    else $error("hardware enable low left converter on");

  a_start_hold: assert property (
    state_r == bfc_pkg::ST_OFF && !hw_assigned && !start_hit
    |=> state_r == bfc_pkg::ST_OFF)
    else $error("converter started outside its slot");

  a_on_code_out: assert property (
    s_on_no_hwc |=> conv_volt_code == $past(on_code_c))
    else $error("ON voltage code not presented");

  a_on_hold: assert property (
    state_r == bfc_pkg::ST_ON && !sleep_hit && !(hw_assigned && !hw_level)
    |=> state_r == bfc_pkg::ST_ON)
    else $error("converter left ON without a slot event");

  a_sleep_hold: assert property (
    state_r == bfc_pkg::ST_SLEEP && !wake_hit
    && !(hw_assigned && !hw_level) |=> state_r == bfc_pkg::ST_SLEEP)
    else $error("converter left SLEEP without a slot event");

  a_hwc_either: assert property (
    cfg.hwc_src == bfc_pkg::SRC_EITHER && hwc2 |-> hwc_active)
    else $error("hardware control 2 ignored with either source");

  a_wake_return: assert property (
    s_wake |=> state_r == bfc_pkg::ST_ON ##1 conv_enable || $past(hwc_off))
    else $error("converter did not wake to ON");

  a_enable_on: assert property (
    state_r != bfc_pkg::ST_OFF && !hwc_off |=> conv_enable)
    else $error("converter off while ON or SLEEP");
endmodule : bfc_buck4_cfg

// [bfc_buck4_cfg_test.sv]
// self-checking testbench for the buck4 configuration bank
`timescale 1ns/10ps
module bfc_buck4_cfg_test;
  logic clock;
  logic rstn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic boot_load;
  logic [4:0] boot_code_hi;
  logic hwctl_pin1;
  logic hwctl_pin2;
  logic hwen_pin1;
  logic hwen_pin2;
  logic seq_valid;
  logic seq_rising;
  logic [2:0] seq_slot;
  logic conv_enable;
  logic [1:0] conv_mode;
  logic [6:0] conv_volt_code;
  logic [11:0] conv_millivolts;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  bfc_buck4_cfg i_bfc_buck4_cfg (.clock(clock), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_load(boot_load),
    .boot_code_hi(boot_code_hi), .hwctl_pin1(hwctl_pin1),
    .hwctl_pin2(hwctl_pin2), .hwen_pin1(hwen_pin1), .hwen_pin2(hwen_pin2),
    .seq_valid(seq_valid), .seq_rising(seq_rising), .seq_slot(seq_slot),
    .conv_enable(conv_enable), .conv_mode(conv_mode),
    .conv_volt_code(conv_volt_code), .conv_millivolts(conv_millivolts));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // no test should come near this; a hang lands in the same report
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic seq(input logic rise, input logic [2:0] slot);
    @(posedge clock);
    seq_valid <= 1'b1;
    seq_rising <= rise;
    seq_slot <= slot;
    @(posedge clock);
    seq_valid <= 1'b0;
  endtask : seq

  // pins pass a two-flop sync, so six edges covers every path
  task automatic exp_conv(input logic en, input logic [1:0] m,
                          input logic [6:0] c);
    repeat (6) @(posedge clock);
    #1 chk(conv_enable, en);
    if (en)
    begin
      chk(conv_mode, m);
      chk(conv_volt_code, c);
      chk(conv_millivolts, bfc_pkg::MV_BASE + bfc_pkg::MV_STEP * c);
    end
  endtask : exp_conv

  task automatic t_reset;
    logic [15:0] d;
    do_reset();
    #1 chk(conv_millivolts, 12'h0352);
    rd(16'h4065, d);
    chk(d, 16'h0300);
    @(posedge clock);
    #1 chk(reg_rdata, 16'h0000);
    rd(16'h4066, d);
    chk(d, 16'h0100);
    rd(16'h4067, d);
    chk(d, 16'h0300);
    wr(16'h4065, 16'hFFFF);
    wr(16'h4066, 16'hFFFF);
    wr(16'h4067, 16'hFFFF);
    wr(16'h4068, 16'hFFFF);
    rd(16'h4065, d);
    chk(d, 16'h1F00);
    rd(16'h4066, d);
    chk(d, 16'hE37F);
    rd(16'h4067, d);
    chk(d, 16'hE37F);
    rd(16'h4068, d);
    chk(d, 16'h0000);
    $display("test reset and masks done");
  endtask : t_reset

  task automatic t_boot;
    logic [15:0] d;
    do_reset();
    wr(16'h4066, 16'h0103);
    @(posedge clock);
    boot_load <= 1'b1;
    boot_code_hi <= 5'h15;
    @(posedge clock);
    boot_load <= 1'b0;
    rd(16'h4066, d);
    chk(d, 16'h0157);
    @(posedge clock);
    boot_load <= 1'b1;
    boot_code_hi <= 5'h1F;
    reg_addr <= 16'h4066;
    reg_wdata <= 16'h0002;
    reg_wr <= 1'b1;
    @(posedge clock);
    boot_load <= 1'b0;
    reg_wr <= 1'b0;
    rd(16'h4066, d);
    chk(d, 16'h0002);
    $display("test boot load done");
  endtask : t_boot

  task automatic t_sleep;
    logic [2:0] tgt [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
    for (int c = 0; c < 8; c++)
    begin
      do_reset();
      wr(16'h4066, 16'h4270);
      wr(16'h4067, {c[2:0], 13'h0110});
      seq(1'b1, 3'h3);
      exp_conv(1'b0, 2'h0, 7'h00);
      seq(1'b1, 3'h2);
      exp_conv(1'b1, 2'h2, 7'h66);
      seq(1'b0, tgt[c]);
      if (c >= 1 && c <= 5)
        exp_conv(1'b0, 2'h0, 7'h00);
      else
      begin
        exp_conv(1'b1, 2'h1, 7'h10);
        seq(1'b1, tgt[c]);
        exp_conv(1'b1, 2'h2, 7'h66);
      end
    end
    $display("test timed start and sleep done");
  endtask : t_sleep

  task automatic t_hwen;
    for (int n = 0; n < 2; n++)
    begin
      do_reset();
      wr(16'h4066, {n[0] ? 3'h7 : 3'h6, 13'h0305});
      wr(16'h4067, 16'h6040);
      exp_conv(1'b0, 2'h0, 7'h00);
      @(posedge clock);
      hwen_pin1 <= ~n[0];
      hwen_pin2 <= n[0];
      exp_conv(1'b1, 2'h3, 7'h05);
      seq(1'b0, 3'h3);
      exp_conv(1'b1, 2'h0, 7'h40);
      @(posedge clock);
      hwen_pin1 <= 1'b0;
      hwen_pin2 <= 1'b0;
      exp_conv(1'b0, 2'h0, 7'h00);
    end
    $display("test hardware enable done");
  endtask : t_hwen

  task automatic t_hwctl;
    logic [15:0] d;
    do_reset();
    wr(16'h4066, 16'h4211);
    wr(16'h4067, 16'h0022);
    seq(1'b1, 3'h2);
    @(posedge clock);
    hwctl_pin1 <= 1'b1;
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 2; p++)
      begin
        wr(16'h4065, {5'h01, p[0], m[1:0], 8'h00});
        exp_conv(m != 1, m[1:0], p ? 7'h22 : 7'h11);
      end
    // source 2 ignores pin 1, then follows pin 2
    wr(16'h4065, 16'h1000);
    exp_conv(1'b1, 2'h2, 7'h11);
    @(posedge clock);
    hwctl_pin2 <= 1'b1;
    exp_conv(1'b1, 2'h0, 7'h11);
    wr(16'h4065, 16'h0000);
    exp_conv(1'b1, 2'h2, 7'h11);
    @(posedge clock);
    hwctl_pin2 <= 1'b0;
    wr(16'h4065, 16'h1C00);
    exp_conv(1'b1, 2'h0, 7'h22);
    rd(16'h40F0, d);
    chk(d, 16'h0038);
    @(posedge clock);
    hwctl_pin1 <= 1'b0;
    $display("test hardware control done");
  endtask : t_hwctl

  initial
  begin
    rstn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    boot_load = 1'b0;
    boot_code_hi = 5'h00;
    hwctl_pin1 = 1'b0;
    hwctl_pin2 = 1'b0;
    hwen_pin1 = 1'b0;
    hwen_pin2 = 1'b0;
    seq_valid = 1'b0;
    seq_rising = 1'b0;
    seq_slot = 3'h0;
    t_reset();
    t_boot();
    t_sleep();
    t_hwen();
    t_hwctl();
    close_out();
  end
endmodule : bfc_buck4_cfg_test
